/* logic/ccsp_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccsp_defs.svh"

module ccsp_top #(
	parameter logic [7:0] DEV_ID0 = 8'h5a, // Arbitrary identification value
	parameter logic [7:0] DEV_ID1 = 8'ha5, // Arbitrary identification value
	parameter logic [7:0] DEV_ID2 = 8'h3c // Arbitrary identification value
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic control_method_pin_i,
	input wire logic wire_count_select_pin_i,
	input wire logic chip_select_latch_pin_i,
	input wire logic serial_clock_i,
	input wire logic serial_data_input_i,
	output logic serial_data_out_o,
	output logic serial_data_oe_n_o,
	output logic serial_readback_output_o,
	output logic serial_readback_oe_n_o,
	input wire logic [7:0] status_error_i,
	input wire logic [7:0] status_chan1_i,
	input wire logic [7:0] status_chan2_i,
	input wire logic [7:0] status_chan3_i,
	input wire logic [7:0] status_chan4_i,
	input wire logic [7:0] status_chan5_i,
	input wire logic [7:0] status_spdif_i,
	output logic hw_mode_o,
	output logic reg_wr_stb_o,
	output logic [6:0] reg_wr_addr_o,
	output logic [8:0] reg_wr_data_o,
	output logic [8:0] readback_control_o
);

	ccsp_pkg::ccsp_state_t st_ff;
	ccsp_pkg::ccsp_state_t nxt_st;
	logic [4:0] pin_level;
	logic [4:0] pin_rise;
	logic [4:0] pin_fall;
	logic scl_lvl;
	logic scl_rise;
	logic scl_fall;
	logic sdi_lvl;
	logic sdi_rise;
	logic sdi_fall;
	logic cs_lvl;
	logic cs_rise;
	logic cs_fall;
	logic sw_mode;
	logic three_wire;
	logic tw_start;
	logic tw_stop;
	logic [6:0] dev_addr;
	// All five control pins pass the synchroniser before use; the status inputs do not
	ccsp_sync #(
		.W(5)
	) u_sync (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.async_i({wire_count_select_pin_i, control_method_pin_i, chip_select_latch_pin_i,
			serial_data_input_i, serial_clock_i}),
		.level_o(pin_level),
		.rise_o(pin_rise),
		.fall_o(pin_fall)
	);
	// Synchronised pin views
	assign scl_lvl = pin_level[0];
	assign scl_rise = pin_rise[0];
	assign scl_fall = pin_fall[0];
	assign sdi_lvl = pin_level[1];
	assign sdi_rise = pin_rise[1];
	assign sdi_fall = pin_fall[1];
	assign cs_lvl = pin_level[2];
	assign cs_rise = pin_rise[2];
	assign cs_fall = pin_fall[2];
	assign sw_mode = ~pin_level[3];
	assign three_wire = pin_level[4];
	assign tw_start = scl_lvl & sdi_fall;
	assign tw_stop = scl_lvl & sdi_rise;
	assign dev_addr = cs_lvl ? `CCSP_TW_ADDR_HI : `CCSP_TW_ADDR_LO;

	// Readable register contents, top bit marks a readable address
	function automatic logic [8:0] rb_lookup(input logic [6:0] a);
		case (a)
			`CCSP_ID0_ADDR: rb_lookup = {1'b1, DEV_ID0};
			`CCSP_ID1_ADDR: rb_lookup = {1'b1, DEV_ID1};
			`CCSP_ID2_ADDR: rb_lookup = {1'b1, DEV_ID2};
			`CCSP_ST_ERR_ADDR: rb_lookup = {1'b1, status_error_i};
			`CCSP_ST_CS1_ADDR: rb_lookup = {1'b1, status_chan1_i};
			`CCSP_ST_CS2_ADDR: rb_lookup = {1'b1, status_chan2_i};
			`CCSP_ST_CS3_ADDR: rb_lookup = {1'b1, status_chan3_i};
			`CCSP_ST_CS4_ADDR: rb_lookup = {1'b1, status_chan4_i};
			`CCSP_ST_CS5_ADDR: rb_lookup = {1'b1, status_chan5_i};
			`CCSP_ST_SPDIF_ADDR: rb_lookup = {1'b1, status_spdif_i};
			default: rb_lookup = 9'h000;
		endcase
	endfunction
	// Selector code to status register address
	function automatic logic [6:0] mux_to_addr(input logic [2:0] m);
		case (m)
			`CCSP_MUX_ERR: mux_to_addr = `CCSP_ST_ERR_ADDR;
			`CCSP_MUX_CS1: mux_to_addr = `CCSP_ST_CS1_ADDR;
			`CCSP_MUX_CS2: mux_to_addr = `CCSP_ST_CS2_ADDR;
			`CCSP_MUX_CS3: mux_to_addr = `CCSP_ST_CS3_ADDR;
			`CCSP_MUX_CS4: mux_to_addr = `CCSP_ST_CS4_ADDR;
			`CCSP_MUX_CS5: mux_to_addr = `CCSP_ST_CS5_ADDR;
			`CCSP_MUX_SPDIF: mux_to_addr = `CCSP_ST_SPDIF_ADDR;
			default: mux_to_addr = `CCSP_NO_ADDR;
		endcase
	endfunction
	// Next-state logic for both protocols and the readback path
	always_comb begin
		logic commit;
		logic [8:0] rb_sel;
		logic [6:0] rb_src;
		commit = 1'b0;
		rb_sel = 9'h000;
		rb_src = `CCSP_NO_ADDR;
		nxt_st = st_ff;
		nxt_st.wr_stb = 1'b0;
		if (!sw_mode) begin
			// Hardware control: serial port stays quiet
			nxt_st.tw_state = ccsp_pkg::TW_IDLE;
			nxt_st.bitcnt = '0;
			nxt_st.sda_drive = 1'b0;
		end else if (three_wire) begin
			nxt_st.tw_state = ccsp_pkg::TW_IDLE;
			nxt_st.sda_drive = 1'b0;
			if (cs_fall) begin
				nxt_st.bitcnt = '0;
				nxt_st.rb_shift = st_ff.rb_byte;
			end else if (scl_rise && !cs_lvl) begin
				nxt_st.shreg = {st_ff.shreg[14:0], sdi_lvl};
				nxt_st.rb_shift = {st_ff.rb_shift[6:0], 1'b0};
				if (st_ff.bitcnt < `CCSP_WORD_BITS) begin
					nxt_st.bitcnt = 5'(st_ff.bitcnt + 5'h01);
				end
			end else if (cs_rise && st_ff.bitcnt == `CCSP_WORD_BITS) begin
				commit = 1'b1;
			end
		end else if (tw_stop) begin
			nxt_st.tw_state = ccsp_pkg::TW_IDLE;
			nxt_st.sda_drive = 1'b0;
		end else begin
			unique case (st_ff.tw_state)
				ccsp_pkg::TW_IDLE, ccsp_pkg::TW_DONE: begin
					if (tw_start) begin
						nxt_st.tw_state = ccsp_pkg::TW_SHIFT;
						nxt_st.bitcnt = '0;
						nxt_st.byte_idx = 2'h0;
						nxt_st.rb_shift = st_ff.rb_byte;
					end
				end
				ccsp_pkg::TW_SHIFT: begin
					if (tw_start) begin
						nxt_st.tw_state = ccsp_pkg::TW_IDLE;
					end else if (scl_rise) begin
						nxt_st.shreg = {st_ff.shreg[14:0], sdi_lvl};
						nxt_st.rb_shift = {st_ff.rb_shift[6:0], 1'b0};
						nxt_st.bitcnt = 5'(st_ff.bitcnt + 5'h01);
						if (st_ff.bitcnt == `CCSP_LAST_BIT) begin
							if (st_ff.byte_idx == 2'h0 && st_ff.shreg[6:0] != dev_addr) begin
								nxt_st.tw_state = ccsp_pkg::TW_IDLE;
							end else begin
								nxt_st.tw_state = ccsp_pkg::TW_ACKW;
							end
						end
					end
				end
				ccsp_pkg::TW_ACKW: begin
					if (tw_start) begin
						nxt_st.tw_state = ccsp_pkg::TW_IDLE;
					end else if (scl_fall) begin
						nxt_st.tw_state = ccsp_pkg::TW_ACKD;
						nxt_st.sda_drive = 1'b1;
					end
				end
				ccsp_pkg::TW_ACKD: begin
					if (tw_start) begin
						nxt_st.tw_state = ccsp_pkg::TW_IDLE;
						nxt_st.sda_drive = 1'b0;
					end else if (scl_fall) begin
						nxt_st.sda_drive = 1'b0;
						nxt_st.bitcnt = '0;
						if (st_ff.byte_idx == `CCSP_LAST_BYTE) begin
							commit = 1'b1;
							nxt_st.tw_state = ccsp_pkg::TW_DONE;
						end else begin
							nxt_st.byte_idx = 2'(st_ff.byte_idx + 2'h1);
							nxt_st.tw_state = ccsp_pkg::TW_SHIFT;
						end
					end
				end
			endcase
		end
		if (commit) begin
			nxt_st.wr_stb = 1'b1;
			nxt_st.wr_addr = st_ff.shreg[15:9];
			nxt_st.wr_data = st_ff.shreg[8:0];
			if (st_ff.rb_ctrl[`CCSP_RB_CONT_BIT]) begin
				rb_src = mux_to_addr(st_ff.rb_ctrl[`CCSP_RB_MUX_MSB:`CCSP_RB_MUX_LSB]);
			end else begin
				rb_src = st_ff.shreg[15:9];
			end
			rb_sel = rb_lookup(rb_src);
			nxt_st.rb_valid = rb_sel[8];
			nxt_st.rb_byte = rb_sel[7:0];
			if (st_ff.shreg[15:9] == `CCSP_RB_CTRL_ADDR) begin
				nxt_st.rb_ctrl = st_ff.shreg[8:0];
			end
		end
		nxt_st.rb_drive = sw_mode & nxt_st.rb_ctrl[`CCSP_RB_EN_BIT] & nxt_st.rb_valid &
			(three_wire ? ~cs_lvl : (nxt_st.tw_state != ccsp_pkg::TW_IDLE));
	end

	// State register
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_ff <= '{tw_state: ccsp_pkg::TW_IDLE, rb_ctrl: `CCSP_RB_CTRL_RST, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs
	assign serial_data_out_o = 1'b0;
	assign serial_data_oe_n_o = ~st_ff.sda_drive;
	assign serial_readback_output_o = st_ff.rb_shift[7];
	assign serial_readback_oe_n_o = ~st_ff.rb_drive;
	assign hw_mode_o = ~sw_mode;
	assign reg_wr_stb_o = st_ff.wr_stb;
	assign reg_wr_addr_o = st_ff.wr_addr;
	assign reg_wr_data_o = st_ff.wr_data;
	assign readback_control_o = st_ff.rb_ctrl;

	// Checks
	sequence s_cs_latch;
		sw_mode && three_wire && cs_rise && st_ff.bitcnt == `CCSP_WORD_BITS;
	endsequence
	sequence s_addr_miss;
		sw_mode && !three_wire && !tw_stop && !tw_start && st_ff.tw_state == ccsp_pkg::TW_SHIFT &&
			scl_rise && st_ff.bitcnt == `CCSP_LAST_BIT && st_ff.byte_idx == 2'h0 &&
			st_ff.shreg[6:0] != dev_addr;
	endsequence
	sequence s_cont_write;
		st_ff.rb_ctrl[`CCSP_RB_CONT_BIT] && nxt_st.wr_stb && st_ff.rb_ctrl[2:0] == `CCSP_MUX_ERR;
	endsequence
	AST_HW_NO_WRITE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!sw_mode [*2] |-> !reg_wr_stb_o)
		else $error("write strobe in hardware control mode");
	AST_LATCH_CS_RISE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		s_cs_latch |=> reg_wr_stb_o && reg_wr_addr_o == $past(st_ff.shreg[15:9]))
		else $error("three-wire word not latched on chip select rise");
	AST_SAMPLE_RISE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		sw_mode && three_wire && !cs_fall && scl_rise && !cs_lvl |=> st_ff.shreg[0] == $past(sdi_lvl))
		else $error("data input not sampled on clock rise");
	AST_RB_CS_HIGH: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		three_wire && cs_lvl && $past(three_wire) && $past(cs_lvl) |-> serial_readback_oe_n_o)
		else $error("readback output driven with chip select high");
	AST_RB_ENABLE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!serial_readback_oe_n_o |-> readback_control_o[`CCSP_RB_EN_BIT])
		else $error("readback output driven while disabled");
	AST_ACK_SLOT: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!serial_data_oe_n_o |-> st_ff.tw_state == ccsp_pkg::TW_ACKD)
		else $error("data line pulled low outside acknowledge");
	AST_ADDR_MISS: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		s_addr_miss |=> st_ff.tw_state == ccsp_pkg::TW_IDLE [*2])
		else $error("address mismatch did not idle");
	AST_STOP_IDLE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		sw_mode && !three_wire && tw_stop |=> st_ff.tw_state == ccsp_pkg::TW_IDLE && serial_data_oe_n_o)
		else $error("stop did not return to idle");
	AST_EARLY_START: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		sw_mode && !three_wire && !tw_stop && tw_start && st_ff.tw_state == ccsp_pkg::TW_SHIFT
		|=> st_ff.tw_state == ccsp_pkg::TW_IDLE)
		else $error("unexpected start did not abandon transfer");
	AST_CONT_SOURCE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		s_cont_write |=> st_ff.rb_valid && st_ff.rb_byte == $past(status_error_i))
		else $error("continuous readback byte wrong");
endmodule

`default_nettype wire

/* logic/ccsp_defs.svh */
`ifndef CCSP_DEFS_SVH
`define CCSP_DEFS_SVH

// Field widths
`define CCSP_ADDR_W 7
`define CCSP_DATA_W 9
`define CCSP_WORD_W 16
`define CCSP_BYTE_W 8
`define CCSP_CNT_W 5
`define CCSP_WORD_BITS 5'h10
`define CCSP_LAST_BIT 5'h07

// Readback control register
`define CCSP_RB_CTRL_ADDR 7'h34
`define CCSP_RB_CTRL_RST 9'h000
`define CCSP_RB_MUX_MSB 2
`define CCSP_RB_MUX_LSB 0
`define CCSP_RB_CONT_BIT 3
`define CCSP_RB_EN_BIT 4

// Readable register addresses
`define CCSP_ID0_ADDR 7'h00
`define CCSP_ID1_ADDR 7'h01
`define CCSP_ID2_ADDR 7'h02
`define CCSP_ST_ERR_ADDR 7'h38
`define CCSP_ST_CS1_ADDR 7'h39
`define CCSP_ST_CS2_ADDR 7'h3a
`define CCSP_ST_CS3_ADDR 7'h3b
`define CCSP_ST_CS4_ADDR 7'h3c
`define CCSP_ST_CS5_ADDR 7'h3d
`define CCSP_ST_SPDIF_ADDR 7'h3e
`define CCSP_NO_ADDR 7'h7f

// Readback source selector codes
`define CCSP_MUX_ERR 3'h0
`define CCSP_MUX_CS1 3'h1
`define CCSP_MUX_CS2 3'h2
`define CCSP_MUX_CS3 3'h3
`define CCSP_MUX_CS4 3'h4
`define CCSP_MUX_CS5 3'h5
`define CCSP_MUX_SPDIF 3'h6

// Two-wire device addresses
`define CCSP_TW_ADDR_LO 7'h1a
`define CCSP_TW_ADDR_HI 7'h1b
`define CCSP_LAST_BYTE 2'h2

`endif

/* logic/ccsp_pkg.sv */
`default_nettype none
`include "ccsp_defs.svh"

package ccsp_pkg;

	// Two-wire receiver states
	typedef enum logic [4:0] {
		TW_IDLE = 5'h01,
		TW_SHIFT = 5'h02,
		TW_ACKW = 5'h04,
		TW_ACKD = 5'h08,
		TW_DONE = 5'h10
	} ccsp_tw_state_t;

	// Complete state of the control port
	typedef struct packed {
		ccsp_tw_state_t tw_state;
		logic [`CCSP_CNT_W-1:0] bitcnt;
		logic [1:0] byte_idx;
		logic [`CCSP_WORD_W-1:0] shreg;
		logic [`CCSP_DATA_W-1:0] rb_ctrl;
		logic [`CCSP_BYTE_W-1:0] rb_byte;
		logic rb_valid;
		logic [`CCSP_BYTE_W-1:0] rb_shift;
		logic rb_drive;
		logic sda_drive;
		logic wr_stb;
		logic [`CCSP_ADDR_W-1:0] wr_addr;
		logic [`CCSP_DATA_W-1:0] wr_data;
	} ccsp_state_t;

endpackage

`default_nettype wire

/* logic/ccsp_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser with a third stage for edge detection
module ccsp_sync #(
	parameter int W = 5
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] level_o,
	output logic [W-1:0] rise_o,
	output logic [W-1:0] fall_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} ccsp_sync_state_t;

	ccsp_sync_state_t st_ff;
	ccsp_sync_state_t nxt_st;

	// Shift the samples down the chain
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = async_i;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
	end

	// State register
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Level and edges come from the second and third stages only
	assign level_o = st_ff.s2;
	assign rise_o = st_ff.s2 & ~st_ff.s3;
	assign fall_o = ~st_ff.s2 & st_ff.s3;

endmodule

`default_nettype wire

/* logic/ccsp_placeholder_unused.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* testbench/ccsp_host.sv */
`timescale 1ns/1ps
`default_nettype none

// Host controller model for the serial control pins
module ccsp_host (
	input wire logic clock_i,
	input wire logic rb_i,
	input wire logic rb_oe_n_i,
	input wire logic wire_i,
	output logic cs_o,
	output logic sclk_o,
	output logic sdi_o,
	output logic sda_low_o
);
	// Idle levels; the serial clock stands still between frames
	initial begin
		cs_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
		sda_low_o = 1'b0;
	end

	// Half period of the 160 ns link clock
	task automatic half();
		repeat (4) @(negedge clock_i);
	endtask

	// One bit: data in low phase, readback taken before the rise
	task automatic bit1(input logic b, input logic tw, output logic r, output logic oen,
		output logic s);
		if (tw) sda_low_o = ~b;
		else sdi_o = b;
		half();
		r = rb_i;
		oen = rb_oe_n_i;
		sclk_o = 1'b1;
		half();
		s = wire_i;
		sclk_o = 1'b0;
	endtask

	// Three-wire frame of n bits
	task automatic spi_write(input logic [15:0] w, input int n, output logic [15:0] cap,
		output logic drv);
		logic r;
		logic oen;
		logic s;
		// chip select low for the whole frame
		cs_o = 1'b0;
		half();
		drv = 1'b1;
		for (int i = 15; i > 15 - n; i--) begin
			bit1(w[i], 1'b0, r, oen, s);
			cap[i] = r;
			drv = drv & ~oen;
		end
		half();
		cs_o = 1'b1;
		// Released data line shows the inverse of its last value
		sdi_o = ~sdi_o;
		half();
	endtask

	// Two-wire transfer of nb bytes with acknowledge slots
	task automatic tw_write(input logic [23:0] w, input int nb, output int acks,
		output logic [7:0] cap, output logic drv);
		logic r;
		logic oen;
		logic s;
		acks = 0;
		drv = 1'b1;
		sclk_o = 1'b1;
		sda_low_o = 1'b0;
		half();
		// start: data falls while clock high
		sda_low_o = 1'b1;
		half();
		sclk_o = 1'b0;
		// bytes MSB first, ninth slot left to the device
		for (int i = 0; i < nb * 9; i++) begin
			bit1((i % 9 == 8) ? 1'b1 : w[23 - i + i / 9], 1'b1, r, oen, s);
			if (i < 8) cap[7 - i] = r;
			if (i < 8) drv = drv & ~oen;
			if (i % 9 == 8 && s === 1'b0) acks++;
		end
		// stop: data rises while clock high
		sda_low_o = 1'b1;
		half();
		sclk_o = 1'b1;
		half();
		sda_low_o = 1'b0;
		half();
	endtask

	// Start, three address bits, then a start out of sequence; bus left with clock low
	task automatic tw_restart();
		logic r;
		logic oen;
		logic s;
		sclk_o = 1'b1;
		sda_low_o = 1'b0;
		half();
		sda_low_o = 1'b1;
		half();
		sclk_o = 1'b0;
		repeat (3) bit1(1'b0, 1'b1, r, oen, s);
		// data falls again while clock high inside the byte
		sda_low_o = 1'b0;
		half();
		sclk_o = 1'b1;
		half();
		sda_low_o = 1'b1;
		half();
		sclk_o = 1'b0;
		half();
	endtask
endmodule

`default_nettype wire

/* testbench/codec_control_serial_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccsp_defs.svh"

module codec_control_serial_port_test;
	localparam logic [7:0] ID0 = 8'h96; // Arbitrary identification value
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hw = 1'b0;
	logic three = 1'b1;
	logic strap = 1'b0;
	logic [7:0] st [7];
	logic h_cs, h_sclk, h_sdi, h_low, sda;
	logic sd_out, sd_oe_n, rb, rb_oe_n, hw_mode, stb;
	logic [6:0] waddr;
	logic [8:0] wdata, rbctl;
	logic [15:0] expq [$];
	logic [15:0] cap;
	logic [7:0] cap8;
	logic drv;
	int acks, seed, fail_count = 0, cmp_count = 0, cycles = 0;
	logic [6:0] na [4] = '{7'h00, 7'h3a, 7'h3e, 7'h10};

	// 50 MHz system clock
	always #10 clk = ~clk;
	// Open-drain data wire with pull-up
	assign sda = h_low ? 1'b0 : ((sd_oe_n === 1'b0) ? sd_out : 1'b1);

	ccsp_top #(.DEV_ID0(ID0)) dut_u (.clock_i(clk), .sys_rst_i(rst),
		.control_method_pin_i(hw), .wire_count_select_pin_i(three),
		.chip_select_latch_pin_i(three ? h_cs : strap), .serial_clock_i(h_sclk),
		.serial_data_input_i(three ? h_sdi : sda), .serial_data_out_o(sd_out),
		.serial_data_oe_n_o(sd_oe_n), .serial_readback_output_o(rb),
		.serial_readback_oe_n_o(rb_oe_n), .status_error_i(st[0]), .status_chan1_i(st[1]),
		.status_chan2_i(st[2]), .status_chan3_i(st[3]), .status_chan4_i(st[4]),
		.status_chan5_i(st[5]), .status_spdif_i(st[6]), .hw_mode_o(hw_mode),
		.reg_wr_stb_o(stb), .reg_wr_addr_o(waddr), .reg_wr_data_o(wdata),
		.readback_control_o(rbctl));

	// Undriven readback pin shows the inverse of the design's bit
	ccsp_host host_u (.clock_i(clk), .rb_i((rb_oe_n === 1'b0) ? rb : ~rb),
		.rb_oe_n_i(rb_oe_n), .wire_i(sda),
		.cs_o(h_cs), .sclk_o(h_sclk), .sdi_o(h_sdi), .sda_low_o(h_low));

	// Compare a seen value with the expected one
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// Three-wire write, noting the expected strobe when q is set
	task automatic wr(input logic [6:0] a, input logic [8:0] d, input logic q);
		if (q) expq.push_back({a, d});
		host_u.spi_write({a, d}, 16, cap, drv);
		repeat (4) @(negedge clk);
		chk(16'(rb_oe_n), 16'h1);
	endtask

	// Every strobe takes the oldest note off the queue; a strobe with no note left counts as an error
	always @(negedge clk) begin
		if (stb === 1'b1) chk({waddr, wdata}, expq.size() ? expq.pop_front() : 16'hxxxx);
	end

	// Cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	// Main sequence
	initial begin
		seed = 46048;
		foreach (st[i]) st[i] = 8'($random(seed));
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (6) @(negedge clk);
		chk(16'(rbctl), 16'h0);
		// Readback disabled: pin never driven
		wr(7'h39, 9'h000, 1'b1);
		wr(7'h20, 9'h000, 1'b1);
		chk(16'(drv), 16'h0);
		// Continuous readback for every selector code
		for (int k = 0; k < 7; k++) begin
			wr(`CCSP_RB_CTRL_ADDR, 9'h018 | 9'(k), 1'b1);
			chk(16'(rbctl), 16'h018 | 16'(k));
			// the read that follows a write is a dummy
			wr(7'(4'($random(seed))), 9'($random(seed)), 1'b1);
			wr(7'h20, 9'($random(seed)), 1'b1);
			chk(16'(cap[15:8]), 16'(st[k]));
			chk(16'(drv), 16'h1);
		end
		// Non-continuous readback of ID, status and a plain register
		wr(`CCSP_RB_CTRL_ADDR, 9'h010, 1'b1);
		for (int k = 0; k < 4; k++) begin
			wr(na[k], 9'h000, 1'b1);
			wr(7'h21, 9'h000, 1'b1);
			if (k < 3) chk(16'(cap[15:8]), 16'(k == 0 ? ID0 : st[k * 4 - 2]));
			chk(16'(drv), 16'(k < 3));
		end
		// A short word is dropped
		host_u.spi_write(16'h1234, 8, cap, drv);
		// Hardware control refuses serial writes
		hw = 1'b1;
		repeat (6) @(negedge clk);
		chk(16'(hw_mode), 16'h1);
		wr(7'h05, 9'h1ff, 1'b0);
		hw = 1'b0;
		three = 1'b0;
		repeat (8) @(negedge clk);
		chk(16'(hw_mode), 16'h0);
		// Two-wire: matching address takes the write, three acknowledges
		expq.push_back({7'h3e, 9'h155});
		host_u.tw_write({`CCSP_TW_ADDR_LO, 1'b0, 7'h3e, 9'h155}, 3, acks, cap8, drv);
		chk(16'(acks), 16'h3);
		host_u.tw_write({`CCSP_TW_ADDR_HI, 1'b0, 16'h2a5}, 3, acks, cap8, drv);
		chk(16'(acks), 16'h0);
		expq.push_back({7'h22, 9'h0aa});
		host_u.tw_write({`CCSP_TW_ADDR_LO, 1'b0, 7'h22, 9'h0aa}, 3, acks, cap8, drv);
		chk(16'(cap8), 16'(st[6]));
		chk(16'(drv), 16'h1);
		strap = 1'b1;
		repeat (8) @(negedge clk);
		expq.push_back({7'h23, 9'h101});
		host_u.tw_write({`CCSP_TW_ADDR_HI, 1'b0, 7'h23, 9'h101}, 3, acks, cap8, drv);
		chk(16'(acks), 16'h3);
		// A start inside the address byte abandons it
		host_u.tw_restart();
		// Stop after the address byte loses the write
		host_u.tw_write({`CCSP_TW_ADDR_HI, 1'b0, 16'hffff}, 1, acks, cap8, drv);
		chk(16'(acks), 16'h1);
		repeat (10) @(negedge clk);
		chk(16'(expq.size()), 16'h0);
		tally_and_finish();
	end
endmodule

`default_nettype wire
